/* File: shared/smsp_params.svh */
/*
 Constants of the serial port: register offsets, field positions,
 reset values and timing counts. Assumes a 16-bit word-addressed frame.
*/
`ifndef SMSP_PARAMS_SVH
`define SMSP_PARAMS_SVH

// register offsets (16-bit word addresses)
`define SMSP_A_CCR 16'h7040
`define SMSP_A_CTL 16'h7041
`define SMSP_A_STS 16'h7042
`define SMSP_A_BRR 16'h7044
`define SMSP_A_RXEMU 16'h7046
`define SMSP_A_RXBUF 16'h7047
`define SMSP_A_TXBUF 16'h7048
`define SMSP_A_DAT 16'h7049
`define SMSP_A_FFTX 16'h704a
`define SMSP_A_FFRX 16'h704b
`define SMSP_A_FFCT 16'h704c
`define SMSP_A_PRI 16'h704f

// config_control fields
`define SMSP_CCR_RUN 7
`define SMSP_CCR_POL 6
// operation_control fields
`define SMSP_CTL_RXIE 0
`define SMSP_CTL_TALK 1
`define SMSP_CTL_MST 2
`define SMSP_CTL_PHA 3
`define SMSP_CTL_OVIE 4
// port_status fields
`define SMSP_STS_OVR 7
`define SMSP_STS_RXF 6
`define SMSP_STS_TXF 5
// queue control fields
`define SMSP_FF_ENH 5
`define SMSP_FF_FLUSH 6
`define SMSP_FF_IE 7

`define SMSP_REG_RST 8'h00

// timing and sizes
`define SMSP_LSP_NS 25
`define SMSP_MIN_BRR 7'h03
`define SMSP_MIN_DIV 8'h04
`define SMSP_DEPTH 5'h10
`define SMSP_STD_DEPTH 5'h02

`endif

/* File: shared/smsp_pkg.sv */
/*
 Types shared by the serial port modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package smsp_pkg;
	typedef logic [15:0] smsp_word_t;
	typedef enum logic [1:0] {SMSP_IDLE, SMSP_RUN, SMSP_GAP} smsp_state_t;
endpackage

/* File: shared/smsp_q_if.sv */
/*
 Valid/ready carrier between the port core and one word queue.
 Assumes owner and store sit on the same clock.
*/
`timescale 1ns/1ps
interface smsp_q_if;
	logic push_valid;
	logic push_ready;
	logic [15:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [15:0] pop_data;
	logic [4:0] level;
	logic deep;
	logic flush;
	modport owner(output push_valid, push_data, pop_ready, deep, flush,
		input push_ready, pop_valid, pop_data, level);
	modport store(input push_valid, push_data, pop_ready, deep, flush,
		output push_ready, pop_valid, pop_data, level);
endinterface

/* File: rtl/smsp_queue.sv */
/*
 Word queue: sixteen entries when deep, two entries otherwise.
 Assumes the owner holds pop_ready only while it consumes a word.
*/
`timescale 1ns/1ps
`include "smsp_params.svh"
module smsp_queue
	import smsp_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	smsp_q_if.store q
);
	smsp_word_t mem [16];
	logic [3:0] wp_r;
	logic [3:0] rp_r;
	logic [4:0] cnt_r;
	logic push;
	logic pop;

	assign push = q.push_valid && q.push_ready;
	assign pop = q.pop_ready && q.pop_valid;
	assign q.push_ready = cnt_r < (q.deep ? `SMSP_DEPTH : `SMSP_STD_DEPTH);
	assign q.pop_valid = cnt_r != 5'h00;
	assign q.pop_data = mem[rp_r];
	assign q.level = cnt_r;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wp_r <= 4'h0;
			rp_r <= 4'h0;
			cnt_r <= 5'h00;
		end else if (ce_i) begin
			if (q.flush) begin
				wp_r <= 4'h0;
				rp_r <= 4'h0;
				cnt_r <= 5'h00;
			end else begin
				if (push)
					wp_r <= wp_r + 4'h1;
				if (pop)
					rp_r <= rp_r + 4'h1;
				cnt_r <= cnt_r + {4'h0, push} - {4'h0, pop};
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (ce_i && push)
			mem[wp_r] <= q.push_data;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i || !ce_i);

	a_queue_bound: assert property (cnt_r <= `SMSP_DEPTH && !(cnt_r == `SMSP_DEPTH && q.push_ready))
		else $error("queue exceeds sixteen words");
	a_queue_count: assert property ((push && !pop && !q.flush) |=> cnt_r == $past(cnt_r) + 5'h01)
		else $error("queue count lost a word");
endmodule

/* File: rtl/smsp_top.sv */
/*
 Synchronous serial port, master or slave, with transmit and receive
 queues behind a 16-bit word-addressed register port.
 Assumes single-cycle reads and writes from a CPU on clock_i, and
 pins that arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`include "smsp_params.svh"
module smsp_top
	import smsp_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	input wire logic serial_bit_clock_i,
	output logic serial_bit_clock_o,
	output logic serial_bit_clock_oe_o,
	input wire logic slave_in_master_out_i,
	output logic slave_in_master_out_o,
	output logic slave_in_master_out_oe_o,
	input wire logic slave_out_master_in_i,
	output logic slave_out_master_in_o,
	output logic slave_out_master_in_oe_o,
	input wire logic slave_transmit_enable_n_i,
	output logic rx_int_o,
	output logic tx_int_o
);
	function automatic smsp_word_t smsp_mask(input logic [3:0] n);
		smsp_word_t m;
		m = 16'hffff >> (4'hf - n);
		return m;
	endfunction

	smsp_q_if tx_if();
	smsp_q_if rx_if();

	logic [7:0] ccr_r, brr_r, fftx_r, ffct_r, pri_r;
	logic [4:0] ctl_r;
	smsp_word_t txb_r, word_r, rx_sh_r, rd_nxt;
	logic ovr_r, out_r, sclk_r, pend_r;
	logic [2:0] clk_s_r, ste_s_r;
	logic [1:0] simo_s_r, somi_s_r, samp_d_r;
	logic [3:0] tx_idx_r, rx_cnt_r;
	logic [4:0] edge_r;
	logic [7:0] div_r, per, h_a, h_b, tg_cnt_r;
	logic [15:0] gap_r;
	smsp_state_t st_r;

	logic [3:0] len;
	logic run, pol, mst, pha, talk, enh, sel;
	assign len = ccr_r[3:0];
	assign run = ccr_r[`SMSP_CCR_RUN];
	assign pol = ccr_r[`SMSP_CCR_POL];
	assign mst = ctl_r[`SMSP_CTL_MST];
	assign pha = ctl_r[`SMSP_CTL_PHA];
	assign talk = ctl_r[`SMSP_CTL_TALK];
	assign enh = fftx_r[`SMSP_FF_ENH];

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: the first stage feeds only the second
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clk_s_r <= 3'h0;
			ste_s_r <= 3'h7;
			simo_s_r <= 2'h0;
			somi_s_r <= 2'h0;
		end else if (ce_i) begin
			clk_s_r <= {clk_s_r[1:0], serial_bit_clock_i};
			ste_s_r <= {ste_s_r[1:0], slave_transmit_enable_n_i};
			simo_s_r <= {simo_s_r[0], slave_in_master_out_i};
			somi_s_r <= {somi_s_r[0], slave_out_master_in_i};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes
	logic wr_ok, wr_sts, tx_flush, rx_flush;
	assign wr_ok = wr_i && ce_i;
	assign wr_sts = wr_ok && addr_i == `SMSP_A_STS;
	assign tx_flush = !run || (wr_ok && addr_i == `SMSP_A_FFTX && wdata_i[`SMSP_FF_FLUSH]);
	assign rx_flush = !run || (wr_ok && addr_i == `SMSP_A_FFRX && wdata_i[`SMSP_FF_FLUSH]);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ccr_r <= `SMSP_REG_RST;
			ctl_r <= 5'h00;
			brr_r <= `SMSP_REG_RST;
			fftx_r <= `SMSP_REG_RST;
			ffct_r <= `SMSP_REG_RST;
			pri_r <= `SMSP_REG_RST;
			txb_r <= 16'h0000;
		end else if (wr_ok) begin
			case (addr_i)
				`SMSP_A_CCR: ccr_r <= wdata_i[7:0];
				`SMSP_A_CTL: ctl_r <= wdata_i[4:0];
				`SMSP_A_BRR: brr_r <= {1'b0, wdata_i[6:0]};
				`SMSP_A_FFTX: fftx_r <= {wdata_i[7], 1'b0, wdata_i[5], 5'h00};
				`SMSP_A_FFCT: ffct_r <= wdata_i[7:0];
				`SMSP_A_PRI: pri_r <= wdata_i[7:0];
				`SMSP_A_TXBUF: txb_r <= wdata_i;
				default: ;
			endcase
		end
	end

	assign tx_if.push_valid = wr_i && (addr_i == `SMSP_A_TXBUF || addr_i == `SMSP_A_DAT);
	assign tx_if.push_data = wdata_i;
	assign tx_if.deep = enh;
	assign tx_if.flush = tx_flush;
	assign rx_if.deep = enh;
	assign rx_if.flush = rx_flush;
	assign rx_if.pop_ready = rd_i && ce_i && addr_i == `SMSP_A_RXBUF;

	////////////////////////////////////////////////////////////////////////
	// register reads, one cycle after rd_i
	always_comb begin
		rd_nxt = 16'h0000;
		case (addr_i)
			`SMSP_A_CCR: rd_nxt = {8'h00, ccr_r};
			`SMSP_A_CTL: rd_nxt = {11'h000, ctl_r};
			`SMSP_A_STS: rd_nxt = {8'h00, ovr_r, rx_if.pop_valid, !tx_if.push_ready, 5'h00};
			`SMSP_A_BRR: rd_nxt = {8'h00, brr_r};
			`SMSP_A_RXEMU: rd_nxt = rx_if.pop_data;
			`SMSP_A_RXBUF: rd_nxt = rx_if.pop_data;
			`SMSP_A_TXBUF: rd_nxt = txb_r;
			`SMSP_A_DAT: rd_nxt = word_r;
			`SMSP_A_FFTX: rd_nxt = {8'h00, fftx_r[7:5], tx_if.level};
			`SMSP_A_FFRX: rd_nxt = {8'h00, 3'h0, rx_if.level};
			`SMSP_A_FFCT: rd_nxt = {8'h00, ffct_r};
			`SMSP_A_PRI: rd_nxt = {8'h00, pri_r};
			default: rd_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			rdata_o <= 16'h0000;
		else if (ce_i && rd_i)
			rdata_o <= rd_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// master bit clock
	// divide by setting plus one, or by four for settings below three
	assign per = (brr_r[6:0] < `SMSP_MIN_BRR) ? `SMSP_MIN_DIV : brr_r + 8'h01;
	// active half gets the floor, idle half the rest, so odd dividers stay exact
	assign h_a = per >> 1;
	assign h_b = per - h_a;

	logic m_tog, m_lead, m_drive, m_samp, m_start, rx_busy;
	assign m_tog = st_r == SMSP_RUN && div_r == 8'h00;
	assign m_lead = sclk_r == pol;
	// drive on first edge without delay
	assign m_drive = m_tog && (m_lead ^ pha);
	// sample on first edge with delay
	assign m_samp = m_tog && !(m_lead ^ pha);
	assign rx_busy = rx_cnt_r != 4'h0 || samp_d_r != 2'h0;
	// receive queue space stalls the master before a word starts
	assign m_start = st_r == SMSP_IDLE && run && mst && tx_if.pop_valid
		&& rx_if.push_ready && !rx_busy;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= SMSP_IDLE;
			sclk_r <= 1'b0;
			div_r <= 8'h00;
			edge_r <= 5'h00;
			gap_r <= 16'h0000;
		end else if (ce_i) begin
			case (st_r)
				SMSP_IDLE: begin
					sclk_r <= pol;
					edge_r <= 5'h00;
					if (m_start) begin
						st_r <= SMSP_RUN;
						div_r <= h_b - 8'h01;
					end
				end
				SMSP_RUN: begin
					if (!run || !mst) begin
						st_r <= SMSP_IDLE;
					end else if (m_tog) begin
						sclk_r <= !sclk_r;
						edge_r <= edge_r + 5'h01;
						div_r <= (!m_lead ? h_b : h_a) - 8'h01;
						if (edge_r == {len, 1'b1}) begin
							st_r <= (ffct_r == 8'h00) ? SMSP_IDLE : SMSP_GAP;
							gap_r <= 16'(ffct_r) * 16'(per) - 16'h0001;
						end
					end else begin
						div_r <= div_r - 8'h01;
					end
				end
				SMSP_GAP: begin
					gap_r <= gap_r - 16'h0001;
					if (gap_r == 16'h0000 || !run)
						st_r <= SMSP_IDLE;
				end
				default: st_r <= SMSP_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slave edge detection on the synchronised clock
	logic s_edge, s_lead, s_drive, s_samp, s_start, s_reload, load_p, drive_p;
	logic samp_p, in_bit, rx_done;
	assign sel = run && !mst && !ste_s_r[1];
	assign s_start = sel && ste_s_r[2];
	assign s_edge = sel && (clk_s_r[1] ^ clk_s_r[2]);
	assign s_lead = clk_s_r[2] == pol;
	assign s_drive = s_edge && (s_lead ^ pha);
	assign s_samp = s_edge && !(s_lead ^ pha);
	// delayed phase reloads on the trailing edge so bit one stays put
	assign s_reload = sel && (pha ? (pend_r && s_drive) : rx_done);

	assign load_p = m_start || s_start || s_reload;
	assign drive_p = mst ? m_drive : s_drive;
	// master samples two cycles late to line up with the synchronised input
	assign samp_p = mst ? samp_d_r[1] : s_samp;
	assign in_bit = mst ? somi_s_r[1] : simo_s_r[1];
	assign rx_done = samp_p && rx_cnt_r == len;
	assign tx_if.pop_ready = load_p;

	////////////////////////////////////////////////////////////////////////
	// transmit shift path
	smsp_word_t ld_word;
	// an empty queue in slave mode shifts out zeros
	assign ld_word = tx_if.pop_valid ? tx_if.pop_data : 16'h0000;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			word_r <= 16'h0000;
			tx_idx_r <= 4'h0;
			out_r <= 1'b0;
			pend_r <= 1'b0;
		end else if (ce_i) begin
			pend_r <= sel && pha && (rx_done || (pend_r && !s_reload));
			if (load_p) begin
				word_r <= ld_word;
				// first bit presented a half cycle early
				if (pha) begin
					out_r <= ld_word[len];
					tx_idx_r <= len - 4'h1;
				end else begin
					tx_idx_r <= len;
				end
			end else if (drive_p) begin
				// most significant of the word first
				out_r <= word_r[tx_idx_r];
				tx_idx_r <= tx_idx_r - 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive shift path
	// receive runs whatever the transmit setting
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_sh_r <= 16'h0000;
			rx_cnt_r <= 4'h0;
			samp_d_r <= 2'h0;
		end else if (ce_i) begin
			samp_d_r <= {samp_d_r[0], m_samp};
			if (!run || (!mst && !sel)) begin
				rx_cnt_r <= 4'h0;
			end else if (samp_p) begin
				rx_sh_r <= {rx_sh_r[14:0], in_bit};
				rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
			end
		end
	end

	assign rx_if.push_valid = rx_done;
	assign rx_if.push_data = {rx_sh_r[14:0], in_bit} & smsp_mask(len);

	// overrun flag, new overrun beats a clear
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			ovr_r <= 1'b0;
		else if (ce_i) begin
			if (rx_done && !rx_if.push_ready)
				ovr_r <= 1'b1;
			else if (wr_sts && wdata_i[`SMSP_STS_OVR])
				ovr_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive and interrupt requests
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			serial_bit_clock_oe_o <= 1'b0;
			slave_in_master_out_oe_o <= 1'b0;
			slave_out_master_in_oe_o <= 1'b0;
			rx_int_o <= 1'b0;
			tx_int_o <= 1'b0;
		end else if (ce_i) begin
			serial_bit_clock_oe_o <= run && mst;
			slave_in_master_out_oe_o <= run && mst && talk;
			slave_out_master_in_oe_o <= sel && talk;
			rx_int_o <= (ctl_r[`SMSP_CTL_RXIE] && rx_if.pop_valid)
				|| (ctl_r[`SMSP_CTL_OVIE] && ovr_r);
			tx_int_o <= enh && fftx_r[`SMSP_FF_IE] && tx_if.level == 5'h00;
		end
	end

	assign serial_bit_clock_o = sclk_r;
	assign slave_in_master_out_o = out_r;
	assign slave_out_master_in_o = out_r;

	smsp_queue u_txq (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.q(tx_if.store)
	);
	smsp_queue u_rxq (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.q(rx_if.store)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			tg_cnt_r <= 8'h00;
		else if (ce_i)
			tg_cnt_r <= (m_tog || st_r != SMSP_RUN) ? 8'h00 : tg_cnt_r + 8'h01;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i || !ce_i);

	a_half_slow: assert property ((m_tog && brr_r[6:0] >= `SMSP_MIN_BRR)
		|-> tg_cnt_r + 8'h01 == (m_lead ? h_b : h_a))
		else $error("bit clock half period wrong");
	a_half_fast: assert property ((m_tog && brr_r[6:0] < `SMSP_MIN_BRR) |-> tg_cnt_r == 8'h01)
		else $error("clamped bit clock half not two cycles");
	a_out_plain: assert property ((st_r == SMSP_RUN && !pha && m_tog && !m_lead) |=> $stable(out_r))
		else $error("data moved on sample edge");
	a_out_delay: assert property ((st_r == SMSP_RUN && pha && m_tog && m_lead) |=> $stable(out_r))
		else $error("delayed data moved on sample edge");
	a_word_len: assert property (rx_if.push_valid |-> $past(rx_cnt_r) == len || $past(samp_p))
		else $error("word pushed at wrong bit count");
	a_talk_off: assert property (!talk |=> !slave_in_master_out_oe_o && !slave_out_master_in_oe_o)
		else $error("driver on with transmit off");
	a_slave_pins: assert property ((!mst || !run) |=> !serial_bit_clock_oe_o && st_r != SMSP_RUN)
		else $error("slave drives bit clock");
	a_upper_zero: assert property ((rd_i && addr_i == `SMSP_A_CTL) |=> rdata_o[15:8] == 8'h00)
		else $error("upper byte not zero");
	a_rx_request: assert property ((rx_if.pop_valid && ctl_r[`SMSP_CTL_RXIE]) |=> rx_int_o)
		else $error("receive request missing");
	a_master_clk: assert property ((run && mst) |=> serial_bit_clock_oe_o)
		else $error("master not driving bit clock");
endmodule

/* File: tb/smsp_slave_model.sv */
/*
 Behavioural serial slave facing the port while the port is master.
 Assumes the bit clock is made on clock_i and toggles only within frames;
 word n sent by the model is base_i + n*0x1357, cut to len_i bits.
*/
`timescale 1ns/1ps
module smsp_slave_model (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic load_i,
	input wire logic pol_i,
	input wire logic pha_i,
	input wire logic [4:0] len_i,
	input wire logic [15:0] base_i,
	input wire logic sclk_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic [15:0] rx_word_o,
	output logic rx_stb_o
);
	logic prev_r;
	logic [3:0] ptr_r;
	logic [4:0] cnt_r;
	logic [15:0] sh_r;
	logic [15:0] nw_r;
	logic [15:0] cur_w;
	logic [15:0] nxt_w;
	logic [15:0] mask;
	logic [3:0] len_m1;
	assign cur_w = base_i + nw_r * 16'h1357;
	assign nxt_w = cur_w + 16'h1357;
	assign mask = 16'hffff >> (5'h10 - len_i);
	assign len_m1 = 4'(len_i - 5'h1);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_r <= 1'b0;
			ptr_r <= 4'h0;
			cnt_r <= 5'h0;
			sh_r <= 16'h0;
			nw_r <= 16'h0;
			miso_o <= 1'b0;
			rx_word_o <= 16'h0;
			rx_stb_o <= 1'b0;
		end else begin
			prev_r <= sclk_i;
			rx_stb_o <= 1'b0;
			if (load_i) begin
				ptr_r <= len_m1;
				cnt_r <= 5'h0;
				nw_r <= 16'h0;
				miso_o <= base_i[len_m1];
			// sample on the edge the port samples on
			end else if (sclk_i != prev_r && (sclk_i != pol_i) == pha_i) begin
				sh_r <= {sh_r[14:0], mosi_i};
				cnt_r <= (cnt_r + 5'h1 == len_i) ? 5'h0 : cnt_r + 5'h1;
				if (cnt_r + 5'h1 == len_i) begin
					rx_word_o <= {sh_r[14:0], mosi_i} & mask;
					rx_stb_o <= 1'b1;
				end
			// drive on the other edge, msb first
			end else if (sclk_i != prev_r) begin
				miso_o <= pha_i ? (ptr_r == 4'h0 ? nxt_w[len_m1] : cur_w[ptr_r - 4'h1])
					: cur_w[ptr_r];
				ptr_r <= (ptr_r == 4'h0) ? len_m1 : ptr_r - 4'h1;
				if (ptr_r == 4'h0) nw_r <= nw_r + 16'h1;
			end
		end
	end
endmodule

/* File: tb/spi_master_slave_port_test.sv */
/*
 Self-checking bench for the serial port top with a slave model.
 Assumes single-cycle register strobes and the hand-over timing.
*/
`timescale 1ns/1ps
`include "smsp_params.svh"
module spi_master_slave_port_test
	import smsp_pkg::*;
;
	logic clock_i, sys_rst_i, wr_i, rd_i, load, pol, pha, noise, sel_n, sclk_q, bad_dir, mo_seen;
	logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, rx_int, tx_int, pmiso, prx_stb;
	logic [15:0] addr_i, wdata_i, rdata_o, prx_word, base;
	logic [4:0] len;
	logic sclk_m, simo_m;
	logic [7:0] sw, sm;
	integer seed, n_errors, check_count, cyc, i, k;
	integer ts[$];
	smsp_word_t pq[$];
	smsp_word_t got;
	logic [6:0] brr_tbl[6] = '{7'h00, 7'h03, 7'h7f, 7'h02, 7'h01, 7'h04};

	smsp_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .addr_i(addr_i),
		.wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
		.serial_bit_clock_i(sclk_m), .serial_bit_clock_o(sclk_o), .serial_bit_clock_oe_o(sclk_oe),
		.slave_in_master_out_i(simo_m), .slave_in_master_out_o(mosi_o),
		.slave_in_master_out_oe_o(mosi_oe), .slave_out_master_in_i(pmiso),
		.slave_out_master_in_o(miso_o), .slave_out_master_in_oe_o(miso_oe),
		.slave_transmit_enable_n_i(sel_n), .rx_int_o(rx_int), .tx_int_o(tx_int));
	smsp_slave_model partner (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .load_i(load),
		.pol_i(pol), .pha_i(pha), .len_i(len), .base_i(base), .sclk_i(sclk_o),
		.mosi_i(mosi_oe ? mosi_o : noise), .miso_o(pmiso), .rx_word_o(prx_word),
		.rx_stb_o(prx_stb));

	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	//////////////////////////////////////////////////////////////////////
	// released data line toggles every cycle so a stale level never matches
	always @(posedge clock_i) begin
		cyc = cyc + 1;
		noise <= ~noise;
		sclk_q <= sclk_o;
		if (prx_stb) pq.push_back(prx_word);
		if (mosi_oe) mo_seen = 1'b1;
		if (sclk_o != sclk_q) ts.push_back(cyc);
		if (sclk_o != sclk_q && (!sclk_oe || miso_oe)) bad_dir = 1'b1;
	end

	task automatic chk(input string what, input smsp_word_t seen, input smsp_word_t exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// every access is one whole 16-bit word
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output smsp_word_t d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		d = rdata_o;
	endtask

	function automatic smsp_word_t ptx(input integer n, input logic [15:0] b, input logic [4:0] l);
		return (b + 16'(n) * 16'h1357) & (16'hffff >> (5'h10 - l));
	endfunction

	//////////////////////////////////////////////////////////////////////
	task automatic run_mode(input integer m);
		smsp_word_t tx[3];
		smsp_word_t ex;
		logic [6:0] brr;
		logic talk;
		brr = (m == 5) ? 7'(4 + {$random(seed)} % 27) : brr_tbl[m];
		talk = (m != 4);
		@(posedge clock_i);
		pol <= m[0];
		pha <= m[1];
		len <= (m == 0) ? 5'h10 : (m == 3) ? 5'h01 : 5'(1 + {$random(seed)} % 16);
		base <= 16'($random(seed));
		wr(`SMSP_A_BRR, {9'h0, brr});
		wr(`SMSP_A_CCR, {8'h0, 1'b1, m[0], 2'b0, 4'(len - 5'h1)});
		wr(`SMSP_A_FFCT, (m == 5) ? 16'h0002 : 16'h0000);
		wr(`SMSP_A_CTL, {12'h0, m[1], 1'b1, talk, 1'b1});
		load <= 1'b1;
		@(posedge clock_i);
		load <= 1'b0;
		// clear off the edge so the old role's last outputs are not recorded
		@(negedge clock_i);
		pq.delete();
		ts.delete();
		mo_seen = 1'b0;
		bad_dir = 1'b0;
		for (i = 0; i < 3; i++) begin
			tx[i] = 16'($random(seed));
			wr(`SMSP_A_TXBUF + 16'(i % 2), tx[i]);
		end
		k = 0;
		got = 16'h0;
		while (got[4:0] !== 5'h03 && k < 20000) begin
			rd(`SMSP_A_FFRX, got);
			k = k + 1;
		end
		if (k == 20000 || pq.size() != 3) begin
			n_errors = n_errors + 1;
			end_sim();
		end
		// the last trailing edge may follow the last sample by a whole slow half
		repeat (70) @(posedge clock_i);
		ex = (brr < 7'h03) ? 16'h4 : 16'(brr) + 16'h1;
		// one-bit words stretch the idle half between words, so time the active half
		if (len == 5'h1) chk("bit half", 16'(ts[1] - ts[0]), ex >> 1);
		else chk("bit period", 16'(ts[2] - ts[0]), ex);
		chk("idle level", {15'h0, sclk_o}, {15'h0, m[0]});
		chk("pin directions", {15'h0, bad_dir}, 16'h0);
		chk("transmit enable", {15'h0, mo_seen}, {15'h0, talk});
		chk("rx interrupt", {15'h0, rx_int}, 16'h1);
		for (i = 0; i < 3; i++) begin
			if (talk) chk("word out", pq[i], tx[i] & (16'hffff >> (5'h10 - len)));
			rd(`SMSP_A_RXBUF, got);
			chk("word in", got, ptx(i, base, len));
		end
		repeat (2) @(posedge clock_i);
		chk("rx interrupt drained", {15'h0, rx_int}, 16'h0);
		$display("mode test %0d done", m);
	endtask

	initial begin
		seed = 3;
		n_errors = 0;
		check_count = 0;
		cyc = 0;
		sys_rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 16'h0;
		wdata_i = 16'h0;
		load = 1'b0;
		pol = 1'b0;
		pha = 1'b0;
		len = 5'h10;
		base = 16'h0;
		noise = 1'b0;
		sel_n = 1'b1;
		sclk_m = 1'b0;
		simo_m = 1'b0;
		repeat (12) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		foreach (brr_tbl[j]) begin
			rd(`SMSP_A_CCR + 16'(j == 5 ? 12 : j == 4 ? 15 : j == 3 ? 10 : j), got);
			chk("reset value", got, 16'h0);
		end
		rd(16'h7043, got);
		chk("unmapped read", got, 16'h0);
		chk("pin enables at reset", {13'h0, sclk_oe, mosi_oe, miso_oe}, 16'h0);
		wr(`SMSP_A_PRI, 16'ha5c3);
		rd(`SMSP_A_PRI, got);
		chk("upper byte", got, 16'h00c3);
		$display("register test done");
		wr(`SMSP_A_CCR, 16'h0080);
		wr(`SMSP_A_CTL, 16'h0002);
		for (i = 0; i < 3; i++) wr(`SMSP_A_TXBUF, 16'($random(seed)));
		rd(`SMSP_A_STS, got);
		chk("small buffer full", got, 16'h0020);
		wr(`SMSP_A_FFTX, 16'h00e0);
		// the request is registered one edge after the enable lands
		@(posedge clock_i);
		@(negedge clock_i);
		chk("tx empty interrupt", {15'h0, tx_int}, 16'h1);
		for (i = 0; i < 17; i++) wr(`SMSP_A_DAT, 16'($random(seed)));
		rd(`SMSP_A_FFTX, got);
		chk("deep queue level", got, 16'h00b0);
		chk("tx interrupt off", {15'h0, tx_int}, 16'h0);
		wr(`SMSP_A_FFTX, 16'h0060);
		rd(`SMSP_A_FFTX, got);
		chk("flushed", got, 16'h0020);
		sw = 8'($random(seed));
		sm = 8'($random(seed));
		wr(`SMSP_A_CCR, 16'h0087);
		wr(`SMSP_A_TXBUF, {8'h00, sw});
		@(posedge clock_i);
		// remote master selects the port by pulling enable low
		sel_n <= 1'b0;
		repeat (6) @(posedge clock_i);
		chk("slave selected drive", {14'h0, sclk_oe, miso_oe}, 16'h1);
		// bench as master, idle low; 8-cycle halves clear the synchroniser
		got = 16'h0;
		for (i = 7; i >= 0; i--) begin
			sclk_m <= 1'b1;
			simo_m <= sm[i];
			repeat (8) @(posedge clock_i);
			got[i] = miso_o;
			sclk_m <= 1'b0;
			repeat (8) @(posedge clock_i);
		end
		chk("slave word out", got, {8'h00, sw});
		rd(`SMSP_A_RXBUF, got);
		chk("slave word in", got, {8'h00, sm});
		@(posedge clock_i);
		sel_n <= 1'b1;
		repeat (6) @(posedge clock_i);
		chk("slave released", {14'h0, sclk_oe, miso_oe}, 16'h0);
		$display("queue and slave test done");
		for (k = 0; k < 6; k++) run_mode(k);
		end_sim();
	end
endmodule
